//--- hdl/etl_pkg.sv
// package for the memory timing configuration loader
// assumes one 100 MHz clock; every slower rate comes from a tick divider
package etl_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 10;
    localparam int REF_CLK_NS = 200;
    localparam int REF_DIV_CYC = (REF_CLK_NS + CLK_NS - 1) / CLK_NS;
    localparam int TM_NS = 20;
    localparam int TM_DIV_CYC = (TM_NS + CLK_NS - 1) / CLK_NS;

    // ------------------------------------------------------------
    // internal scan
    // ------------------------------------------------------------
    localparam int INT_SCAN_PERIODS = 144;
    localparam int INT_SCAN_ACTIVE = 64;
    localparam int LINE_STEP = 2;
    localparam int NUM_LINES = 32;
    localparam int DEFAULT_LINE = 31;

    // ------------------------------------------------------------
    // external scan, default preset cycle of 24 units
    // ------------------------------------------------------------
    localparam int EXT_READS = 36;
    localparam logic [31:0] SCAN_BASE_ADDR = 32'h7fffff6c;
    localparam int READ_UNITS = 24;
    localparam int READ_LOW_FIRST = 12;
    localparam int READ_LOW_LAST = 19;
    localparam int SAMPLE_UNIT = 19;
    localparam int FLD_PHASE = 0;
    localparam int FLD_STROBE = 12;
    localparam int STROBE_FIELD_BITS = 20;
    localparam int FLD_RF_INT = 32;
    localparam int FLD_RF_EN = 34;
    localparam int FLD_LATE = 35;
    localparam int RF_STEP = 18;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CFG_LO = 8'h08;
    localparam logic [7:0] REG_CFG_HI = 8'h0c;
    localparam int CTRL_HOLD = 0;
    localparam int ST_DONE = 0;
    localparam int ST_INTERNAL = 1;
    localparam int ST_EXTMODE = 2;
    localparam int ST_LINE = 8;

    typedef enum {ST_START, ST_INT, ST_EXT, ST_FIN} etl_state_t;

    typedef struct packed {
        logic [5:0][2:0] phaseLen;
        logic [3:0][4:0] strobeCoef;
        logic lateWrite;
        logic refreshEn;
        logic [6:0] refreshInterval;
        logic alignUnit;
        logic [3:0] cycleTime;
    } etl_cfg_t;

    localparam etl_cfg_t CFG_RESET = '0;

    // alignment unit pads an odd unit total so t1 starts on a cpu clock rising edge
    function automatic etl_cfg_t etl_make_cfg(input logic [5:0][2:0] ph,
                                              input logic [3:0][4:0] st,
                                              input logic late,
                                              input logic rfEn,
                                              input logic [6:0] rfInt);
        etl_cfg_t c;
        logic [4:0] units;
        units = 5'h0;
        for (int i = 0; i < 6; i++)
        begin
            units = units + 5'(ph[i]);
        end
        c.phaseLen = ph;
        c.strobeCoef = st;
        c.lateWrite = late;
        c.refreshEn = rfEn;
        c.refreshInterval = rfInt;
        c.alignUnit = units[0];
        c.cycleTime = 4'((units + 5'(units[0])) >> 1);
        return c;
    endfunction : etl_make_cfg

    // phases given t6..t1, strobes s4..s1
    function automatic etl_cfg_t etl_preset(input logic [4:0] line);
        etl_cfg_t c;
        unique case (line)
            5'h00: c = etl_make_cfg({3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1},
                                    {5'h05, 5'h03, 5'h01, 5'h1e}, 1'b1, 1'b1, 7'h48);
            5'h01: c = etl_make_cfg({3'h2, 3'h1, 3'h1, 3'h1, 3'h2, 3'h1},
                                    {5'h07, 5'h02, 5'h01, 5'h1e}, 1'b1, 1'b1, 7'h48);
            5'h02: c = etl_make_cfg({3'h3, 3'h2, 3'h1, 3'h1, 3'h2, 3'h1},
                                    {5'h07, 5'h02, 5'h01, 5'h1e}, 1'b1, 1'b1, 7'h48);
            5'h03: c = etl_make_cfg({3'h3, 3'h2, 3'h1, 3'h1, 3'h3, 3'h2},
                                    {5'h08, 5'h03, 5'h01, 5'h1e}, 1'b1, 1'b1, 7'h48);
            5'h04: c = etl_make_cfg({3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1},
                                    {5'h03, 5'h02, 5'h01, 5'h03}, 1'b0, 1'b1, 7'h48);
            5'h05: c = etl_make_cfg({3'h1, 3'h2, 3'h1, 3'h2, 3'h1, 3'h1},
                                    {5'h03, 5'h02, 5'h01, 5'h05}, 1'b0, 1'b1, 7'h48);
            5'h06: c = etl_make_cfg({3'h1, 3'h3, 3'h1, 3'h2, 3'h1, 3'h2},
                                    {5'h03, 5'h02, 5'h01, 5'h06}, 1'b0, 1'b1, 7'h48);
            5'h07: c = etl_make_cfg({3'h2, 3'h3, 3'h1, 3'h2, 3'h2, 3'h2},
                                    {5'h04, 5'h03, 5'h01, 5'h07}, 1'b0, 1'b1, 7'h48);
            5'h08: c = etl_make_cfg({3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1},
                                    {5'h03, 5'h02, 5'h01, 5'h1e}, 1'b0, 1'b0, 7'h00);
            5'h09: c = etl_make_cfg({3'h1, 3'h2, 3'h1, 3'h2, 3'h1, 3'h1},
                                    {5'h09, 5'h05, 5'h02, 5'h1e}, 1'b0, 1'b0, 7'h00);
            5'h0a: c = etl_make_cfg({3'h2, 3'h4, 3'h2, 3'h2, 3'h2, 3'h2},
                                    {5'h08, 5'h03, 5'h02, 5'h1e}, 1'b1, 1'b1, 7'h48);
            5'h0b: c = etl_make_cfg({3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3},
                                    {5'h0d, 5'h04, 5'h02, 5'h1e}, 1'b1, 1'b1, 7'h48);
            default: c = etl_make_cfg({3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4},
                                      {5'h12, 5'h1e, 5'h1e, 5'h1f}, 1'b1, 1'b1, 7'h48);
        endcase
        return c;
    endfunction : etl_preset

endpackage : etl_pkg

//--- hdl/etl_tick_div.sv
// one-cycle enable pulse every DIV clocks
// assumes clear is held while the consumer is idle, restarting the phase
`timescale 1ns/1ps
module etl_tick_div #(
    parameter int DIV = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clear,
    output logic tick
);
    localparam int W = (DIV > 1) ? $clog2(DIV) : 1;

    logic [W-1:0] cnt_q;
    logic tick_q;

    always_ff @(posedge clk)
    begin
        if (!rst_n || clear)
        begin
            cnt_q <= '0;
        end
        else if (cnt_q == W'(DIV - 1))
        begin
            cnt_q <= '0;
        end
        else
        begin
            cnt_q <= cnt_q + W'(1);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n || clear)
        begin
            tick_q <= 1'b0;
        end
        else
        begin
            tick_q <= (cnt_q == W'(DIV - 1));
        end
    end

    assign tick = tick_q;
endmodule : etl_tick_div

//--- hdl/etl_config_loader.sv
// memory timing configuration loader: internal line scan then external rom scan
// assumes pins synchronous to clk; a classic wishbone master reaches the registers
//
// The Wishbone interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module etl_config_loader #(
    parameter int REF_DIV = etl_pkg::REF_DIV_CYC,
    parameter int TM_DIV = etl_pkg::TM_DIV_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic timingSetupInput,
    output logic writeFlagBit0Line,
    output logic refreshFlagBit1Line,
    output logic [31:2] muxedBusLines,
    output logic readStrobeN,
    output logic configDone,
    output logic accessEnable,
    output etl_pkg::etl_cfg_t emiConfig,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);

    // ------------------------------------------------------------
    // state and storage
    // ------------------------------------------------------------
    etl_pkg::etl_state_t state_q;
    logic refTick;
    logic tmTick;
    logic [7:0] refCnt_q;
    logic prevCfg_q;
    logic extMode_q;
    logic found_q;
    logic [4:0] lineIdx_q;
    logic [4:0] unitCnt_q;
    logic [5:0] readIdx_q;
    logic [35:0] bits_q;
    logic [31:0] lines_q;
    logic readN_q;
    logic intUsed_q;
    logic done_q;
    logic hold_q;
    logic access_q;
    etl_pkg::etl_cfg_t cfg_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic intEnd;
    logic unitEnd;
    logic lastRead;
    logic wbReq;

    assign intEnd = refTick && refCnt_q == 8'(etl_pkg::INT_SCAN_PERIODS - 1);
    assign unitEnd = tmTick && unitCnt_q == 5'(etl_pkg::READ_UNITS - 1);
    assign lastRead = readIdx_q == 6'(etl_pkg::EXT_READS - 1);
    assign wbReq = wb_cyc_i && wb_stb_i && !ack_q;

    // word address for a scan read; low two lines carry the inactive flags
    function automatic logic [31:0] scanWord(input logic [5:0] idx);
        logic [31:0] a;
        a = etl_pkg::SCAN_BASE_ADDR + {24'h0, idx, 2'b00};
        scanWord = {a[31:2], 2'b11};
    endfunction : scanWord

    // inverted pin bits decoded into a configuration
    function automatic etl_pkg::etl_cfg_t extCfg(input logic [35:0] b);
        logic [5:0][2:0] ph;
        logic [3:0][4:0] st;
        logic [6:0] rf;
        for (int i = 0; i < 6; i++)
        begin
            ph[i] = 3'(b[etl_pkg::FLD_PHASE + 2 * i +: 2]) + 3'h1;
        end
        st = b[etl_pkg::FLD_STROBE +: etl_pkg::STROBE_FIELD_BITS];
        rf = 7'(etl_pkg::RF_STEP) * (7'(b[etl_pkg::FLD_RF_INT +: 2]) + 7'h1);
        extCfg = etl_pkg::etl_make_cfg(ph, st, b[etl_pkg::FLD_LATE],
                                       b[etl_pkg::FLD_RF_EN], rf);
    endfunction : extCfg

    // ------------------------------------------------------------
    // rate dividers
    // ------------------------------------------------------------
    etl_tick_div #(
        .DIV(REF_DIV)
    ) u_refDiv (
        .clk(clk),
        .rst_n(rst_n),
        .clear(state_q != etl_pkg::ST_INT),
        .tick(refTick)
    );

    etl_tick_div #(
        .DIV(TM_DIV)
    ) u_tmDiv (
        .clk(clk),
        .rst_n(rst_n),
        .clear(state_q != etl_pkg::ST_EXT),
        .tick(tmTick)
    );

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_q <= etl_pkg::ST_START;
        end
        else
        begin
            unique case (state_q)
                etl_pkg::ST_START: state_q <= etl_pkg::ST_INT;
                etl_pkg::ST_INT:
                begin
                    if (intEnd)
                    begin
                        state_q <= etl_pkg::ST_EXT;
                    end
                end
                etl_pkg::ST_EXT:
                begin
                    if (unitEnd && lastRead)
                    begin
                        state_q <= etl_pkg::ST_FIN;
                    end
                end
                etl_pkg::ST_FIN: state_q <= etl_pkg::ST_FIN;
            endcase
        end
    end

    // ------------------------------------------------------------
    // internal scan
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n || state_q != etl_pkg::ST_INT)
        begin
            refCnt_q <= 8'h00;
        end
        else if (refTick)
        begin
            refCnt_q <= refCnt_q + 8'h01;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            prevCfg_q <= 1'b1;
        end
        else if (state_q == etl_pkg::ST_INT && refTick)
        begin
            prevCfg_q <= timingSetupInput;
        end
    end

    // a line falls on even periods; the pin is judged one period later
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            extMode_q <= 1'b0;
            found_q <= 1'b0;
            lineIdx_q <= 5'(etl_pkg::DEFAULT_LINE);
        end
        else if (state_q == etl_pkg::ST_INT && refTick && refCnt_q[0]
                 && refCnt_q < 8'(etl_pkg::INT_SCAN_ACTIVE))
        begin
            if (refCnt_q == 8'(etl_pkg::LINE_STEP - 1) && !prevCfg_q && !timingSetupInput)
            begin
                extMode_q <= 1'b1;
            end
            else if (!found_q && !extMode_q && prevCfg_q && !timingSetupInput)
            begin
                found_q <= 1'b1;
                lineIdx_q <= refCnt_q[5:1];
            end
        end
    end

    // ------------------------------------------------------------
    // bus lines: falling pattern, then scan addresses
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            lines_q <= '1;
        end
        else
        begin
            unique case (state_q)
                etl_pkg::ST_START: lines_q <= '1;
                etl_pkg::ST_INT:
                begin
                    if (intEnd)
                    begin
                        lines_q <= scanWord(6'h00);
                    end
                    else if (refTick && !refCnt_q[0]
                             && refCnt_q < 8'(etl_pkg::INT_SCAN_ACTIVE))
                    begin
                        lines_q[refCnt_q[5:1]] <= 1'b0;
                    end
                end
                etl_pkg::ST_EXT:
                begin
                    if (unitEnd && lastRead)
                    begin
                        lines_q <= '1;
                    end
                    else if (unitEnd)
                    begin
                        lines_q <= scanWord(readIdx_q + 6'h01);
                    end
                end
                etl_pkg::ST_FIN: lines_q <= '1;
            endcase
        end
    end

    // ------------------------------------------------------------
    // external scan reads, default preset timing
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n || state_q != etl_pkg::ST_EXT)
        begin
            unitCnt_q <= 5'h00;
            readIdx_q <= 6'h00;
        end
        else if (unitEnd)
        begin
            unitCnt_q <= 5'h00;
            readIdx_q <= readIdx_q + 6'h01;
        end
        else if (tmTick)
        begin
            unitCnt_q <= unitCnt_q + 5'h01;
        end
    end

    // read strobe covers t4 and t5 of the 4-4-4-4-4-4 cycle
    always_ff @(posedge clk)
    begin
        if (!rst_n || state_q != etl_pkg::ST_EXT)
        begin
            readN_q <= 1'b1;
        end
        else if (tmTick && unitCnt_q == 5'(etl_pkg::READ_LOW_FIRST - 1))
        begin
            readN_q <= 1'b0;
        end
        else if (tmTick && unitCnt_q == 5'(etl_pkg::READ_LOW_LAST))
        begin
            readN_q <= 1'b1;
        end
    end

    // sampled at the end of the read; data bus is never looked at
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            bits_q <= '0;
        end
        else if (state_q == etl_pkg::ST_EXT && tmTick
                 && unitCnt_q == 5'(etl_pkg::SAMPLE_UNIT))
        begin
            bits_q[readIdx_q] <= ~timingSetupInput;
        end
    end

    // ------------------------------------------------------------
    // final configuration
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cfg_q <= etl_pkg::CFG_RESET;
            intUsed_q <= 1'b0;
            done_q <= 1'b0;
        end
        else if (state_q == etl_pkg::ST_EXT && unitEnd && lastRead)
        begin
            done_q <= 1'b1;
            intUsed_q <= !extMode_q;
            if (extMode_q)
            begin
                cfg_q <= extCfg(bits_q);
            end
            else
            begin
                cfg_q <= etl_pkg::etl_preset(lineIdx_q);
            end
        end
    end

    // software may keep accesses gated past the scans
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            access_q <= 1'b0;
        end
        else
        begin
            access_q <= done_q && !hold_q;
        end
    end

    // ------------------------------------------------------------
    // wishbone slave, ack one cycle after the request
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= wbReq;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            hold_q <= 1'b0;
        end
        else if (wbReq && wb_we_i && wb_sel_i[0] && wb_adr_i == etl_pkg::REG_CTRL)
        begin
            hold_q <= wb_dat_i[etl_pkg::CTRL_HOLD];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rdat_q <= 32'h0;
        end
        else if (wbReq)
        begin
            rdat_q <= 32'h0;
            unique case (wb_adr_i)
                etl_pkg::REG_CTRL: rdat_q[etl_pkg::CTRL_HOLD] <= hold_q;
                etl_pkg::REG_STATUS:
                begin
                    rdat_q[etl_pkg::ST_DONE] <= done_q;
                    rdat_q[etl_pkg::ST_INTERNAL] <= intUsed_q;
                    rdat_q[etl_pkg::ST_EXTMODE] <= extMode_q;
                    rdat_q[etl_pkg::ST_LINE +: 5] <= lineIdx_q;
                end
                etl_pkg::REG_CFG_LO: rdat_q <= cfg_q[31:0];
                etl_pkg::REG_CFG_HI: rdat_q <= {12'h0, cfg_q[51:32]};
                default: rdat_q <= 32'h0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign writeFlagBit0Line = lines_q[0];
    assign refreshFlagBit1Line = lines_q[1];
    assign muxedBusLines = lines_q[31:2];
    assign readStrobeN = readN_q;
    assign configDone = done_q;
    assign accessEnable = access_q;
    assign emiConfig = cfg_q;
    assign wb_dat_o = rdat_q;
    assign wb_ack_o = ack_q;

endmodule : etl_config_loader

//--- verification/etl_config_loader_props.sv
// checker on the loader ports: scan timing, latching and bus handshake
// assumes one clock domain and the same divider parameters as the loader
`timescale 1ns/1ps
module etl_config_loader_props #(
    parameter int REF_DIV = etl_pkg::REF_DIV_CYC,
    parameter int TM_DIV = etl_pkg::TM_DIV_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic timingSetupInput,
    input wire logic writeFlagBit0Line,
    input wire logic refreshFlagBit1Line,
    input wire logic [31:2] muxedBusLines,
    input wire logic readStrobeN,
    input wire logic configDone,
    input wire logic accessEnable,
    input wire etl_pkg::etl_cfg_t emiConfig,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o
);
    // two reference periods between lines, 8 and 16 units inside a read
    localparam int LINE_GAP = 2 * REF_DIV;
    localparam int STB_LOW = 8 * TM_DIV;
    localparam int STB_GAP = 16 * TM_DIV;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    line_step_a: assert property ($fell(writeFlagBit0Line) |-> ##LINE_GAP $fell(refreshFlagBit1Line))
        else $error("refresh flag line did not fall two periods after write flag line");
    strobe_len_a: assert property ($fell(readStrobeN) |-> ##STB_LOW $rose(readStrobeN))
        else $error("scan read strobe low time wrong");
    strobe_gap_a: assert property ($rose(readStrobeN) |-> ##STB_GAP ($fell(readStrobeN) || configDone))
        else $error("scan reads not back to back");
    addr_top_a: assert property (!readStrobeN |-> muxedBusLines[31:8] == 24'h7fffff)
        else $error("scan address outside top of map");
    cfg_hold_a: assert property (configDone |=> configDone && $stable(emiConfig))
        else $error("configuration changed after loading");
    cfg_zero_a: assert property (!configDone |-> emiConfig == '0)
        else $error("configuration shown before scans finished");
    access_gate_a: assert property (accessEnable |-> configDone)
        else $error("access allowed before scans finished");
    access_late_a: assert property ($rose(configDone) |-> !accessEnable ##1 accessEnable)
        else $error("access enable not one cycle after done");
    strobe_pre_a: assert property (!readStrobeN |-> !configDone)
        else $error("scan read after done");
    ack_pulse_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a one cycle answer");
endmodule : etl_config_loader_props

bind etl_config_loader etl_config_loader_props #(.REF_DIV(REF_DIV), .TM_DIV(TM_DIV)) props_inst (
    .clk, .rst_n, .timingSetupInput, .writeFlagBit0Line, .refreshFlagBit1Line, .muxedBusLines,
    .readStrobeN, .configDone, .accessEnable, .emiConfig, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o);

//--- verification/etl_rom_model.sv
// board wiring and top-of-map rom on the setup input
// assumes word address on muxedBusLines while the read strobe is low
`timescale 1ns/1ps
module etl_rom_model (
    input wire logic [1:0] mode,
    input wire logic [4:0] line,
    input wire logic [35:0] img,
    input wire logic writeFlagBit0Line,
    input wire logic refreshFlagBit1Line,
    input wire logic [31:2] muxedBusLines,
    input wire logic readStrobeN,
    output logic timingSetupInput
);
    logic [31:0] lines;
    logic [31:0] idx;
    assign lines = {muxedBusLines, refreshFlagBit1Line, writeFlagBit0Line};
    assign idx = ({muxedBusLines, 2'b00} - 32'h7fffff6c) >> 2;
    // mode 0 wired to a line, 1 rom via inverter, 2 tied high
    // released data line is pulled up, so the inverter then shows low
    always_comb
    begin
        if (mode == 2'd2)
            timingSetupInput = 1'b1;
        else if (mode == 2'd0)
            timingSetupInput = lines[line];
        else if (!readStrobeN && idx < 36)
            timingSetupInput = ~img[idx[5:0]];
        else
            timingSetupInput = 1'b0;
    end
endmodule : etl_rom_model

//--- verification/etl_config_loader_tb.sv
// bench: tied, wired and rom-fed setups, then register reads
// assumes short dividers so each scan pair takes about two thousand clocks
`timescale 1ns/1ps
module etl_config_loader_tb;
    localparam etl_pkg::etl_cfg_t DEF = {18'h24924, 20'h97bdf, 14'h390c};
    logic clk, rst_n, timingSetupInput, writeFlagBit0Line, refreshFlagBit1Line;
    logic readStrobeN, configDone, accessEnable, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [31:2] muxedBusLines;
    logic [7:0] wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [3:0] wb_sel_i;
    logic [1:0] mode;
    logic [4:0] line;
    logic [35:0] img;
    etl_pkg::etl_cfg_t emiConfig;
    int nFail, totalChecks, cycles;
    etl_config_loader #(.REF_DIV(2), .TM_DIV(2)) etl_config_loader_inst (.clk, .rst_n,
        .timingSetupInput, .writeFlagBit0Line, .refreshFlagBit1Line, .muxedBusLines,
        .readStrobeN, .configDone, .accessEnable, .emiConfig, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o);
    etl_rom_model etl_rom_model_inst (.mode, .line, .img, .writeFlagBit0Line,
        .refreshFlagBit1Line, .muxedBusLines, .readStrobeN, .timingSetupInput);
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // five scan pairs fit well inside this ceiling
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            nFail++;
            stop_test();
        end
    end
    task automatic chk(input string nm, input logic [51:0] e, input logic [51:0] g);
        totalChecks++;
        if (g !== e)
        begin
            nFail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do
            @(posedge clk);
        while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb
    task automatic run(input logic [1:0] m, input logic [4:0] l, input logic [35:0] i);
        @(posedge clk);
        rst_n <= 1'b0;
        mode <= m;
        line <= l;
        img <= i;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        while (configDone !== 1'b1)
            @(posedge clk);
        repeat (2) @(posedge clk);
    endtask : run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", totalChecks, nFail);
        if (nFail == 0 && totalChecks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test
    initial
    begin
        rst_n = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_dat_i = 32'h0;
        wb_sel_i = 4'hf;
        mode = 2'd2;
        line = 5'h00;
        img = 36'h0;
        nFail = 0;
        totalChecks = 0;
        cycles = 0;
        run(2'd2, 5'h00, 36'h0);
        chk("cfg tied high", DEF, emiConfig);
        wb(1'b0, etl_pkg::REG_STATUS, 32'h0);
        chk("status", 52'(32'h1f03), 52'(rd));
        wb(1'b0, etl_pkg::REG_CFG_LO, 32'h0);
        chk("cfg low word", 52'(DEF[31:0]), 52'(rd));
        wb(1'b1, etl_pkg::REG_CTRL, 32'h1);
        repeat (2) @(posedge clk);
        chk("access held", 52'(1'b0), 52'(accessEnable));
        wb(1'b0, 8'h40, 32'h0);
        chk("unmapped", 52'h0, 52'(rd));
        run(2'd0, 5'h09, 36'h0);
        chk("cfg static", {18'h0a289, 20'h4945e, 14'h0004}, emiConfig);
        wb(1'b0, etl_pkg::REG_STATUS, 32'h0);
        chk("status", 52'(32'h0903), 52'(rd));
        run(2'd0, 5'h00, 36'h0);
        chk("cfg line 0", {18'h09249, 20'h28c3e, 14'h3903}, emiConfig);
        run(2'd1, 5'h00, 36'h5e0d55001);
        chk("cfg rom", {18'h0924a, 20'he0d55, 14'h1494}, emiConfig);
        wb(1'b0, etl_pkg::REG_STATUS, 32'h0);
        chk("status", 52'(3'b101), 52'(rd[2:0]));
        run(2'd1, 5'h00, 36'hfffffffff);
        chk("cfg pin low", {18'h24924, 20'hfffff, 14'h390c}, emiConfig);
        stop_test();
    end
endmodule : etl_config_loader_tb
